// ### core/icc_pkg.sv
package icc_pkg;

    // Capture word width and buffer geometry.
    localparam int ICC_DATA_W = 32;
    localparam int ICC_ADDR_W = 4;
    localparam int ICC_DEPTH = 4;
    localparam int ICC_PTR_W = 2;
    localparam int ICC_CNT_W = 3;

    // Register byte offsets.
    localparam logic [ICC_ADDR_W-1:0] ICC_OFS_CTRL = 4'h0;
    localparam logic [ICC_ADDR_W-1:0] ICC_OFS_BUF = 4'h4;
    localparam logic [ICC_ADDR_W-1:0] ICC_OFS_STAT = 4'h8;
    localparam logic [ICC_ADDR_W-1:0] ICC_OFS_MASK = 4'hc;

    // Field positions inside the control register.
    localparam int ICC_BIT_ENABLE = 15;
    localparam int ICC_BIT_STOP_IN_IDLE = 13;
    localparam int ICC_BIT_FIRST_EDGE_SELECT = 9;
    localparam int ICC_BIT_WIDE = 8;
    localparam int ICC_BIT_TSEL = 7;
    localparam int ICC_BIT_RATE = 5;
    localparam int ICC_BIT_OVF = 4;
    localparam int ICC_BIT_BNE = 3;
    localparam int ICC_BIT_MODE = 0;

    // Interrupt status bit positions and width.
    localparam int ICC_IRQ_W = 2;
    localparam int ICC_IRQ_CAPTURE = 0;
    localparam int ICC_IRQ_OVERFLOW = 1;
    localparam logic [ICC_IRQ_W-1:0] ICC_IRQ_RST = 2'h0;

    // Prescaler terminal counts for the every-4th and every-16th modes.
    localparam logic [3:0] ICC_PRESCALE_4 = 4'h3;
    localparam logic [3:0] ICC_PRESCALE_16 = 4'hf;

    // Capture mode codes.
    typedef enum logic [2:0] {
        ICC_MODE_OFF = 3'h0,
        ICC_MODE_EVERY_EDGE = 3'h1,
        ICC_MODE_FALL = 3'h2,
        ICC_MODE_RISE = 3'h3,
        ICC_MODE_RISE_4 = 3'h4,
        ICC_MODE_RISE_16 = 3'h5,
        ICC_MODE_ALTERNATE = 3'h6,
        ICC_MODE_ANY_EDGE = 3'h7
    } icc_mode_t;

    // Writable control fields.
    typedef struct packed {
        logic enable;
        logic stop_in_idle;
        logic first_edge_select;
        logic wide_capture_select;
        logic timer_source_select;
        logic [1:0] interrupt_rate;
        icc_mode_t capture_mode_field;
    } icc_ctrl_t;

    localparam icc_ctrl_t ICC_CTRL_RST = '0;

    // Register selector produced by the address decoder.
    typedef enum logic [2:0] {
        ICC_SEL_NONE = 3'h0,
        ICC_SEL_CTRL = 3'h1,
        ICC_SEL_BUF = 3'h2,
        ICC_SEL_STAT = 3'h3,
        ICC_SEL_MASK = 3'h4
    } icc_sel_t;

    // Maps a byte address onto a register; unmapped addresses give none.
    function automatic icc_sel_t icc_decode(input logic [ICC_ADDR_W-1:0] addr);
        icc_sel_t sel;
        sel = ICC_SEL_NONE;
        if (addr == ICC_OFS_CTRL) begin
            sel = ICC_SEL_CTRL;
        end else if (addr == ICC_OFS_BUF) begin
            sel = ICC_SEL_BUF;
        end else if (addr == ICC_OFS_STAT) begin
            sel = ICC_SEL_STAT;
        end else if (addr == ICC_OFS_MASK) begin
            sel = ICC_SEL_MASK;
        end
        return sel;
    endfunction : icc_decode

endpackage : icc_pkg

// ### core/icc_edge_sync.sv
`timescale 1ns/1ps
// Brings the capture pin into the clock domain and reports its edges.
module icc_edge_sync
    import icc_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic pin_in,
    output logic rise_out,
    output logic fall_out
);

    logic meta_q; // First stage; only the second stage reads it.
    logic sync_q; // Second stage, safe to use.
    logic prev_q; // Delayed copy for edge detection.
    logic meta_d;
    logic sync_d;
    logic prev_d;

    // Next values of the synchroniser chain.
    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // Registers of the chain; reset to low so no false edge appears.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Edge pulses are one cycle long and look only at settled stages.
    assign rise_out = sync_q & ~prev_q;
    assign fall_out = ~sync_q & prev_q;

endmodule : icc_edge_sync

// ### core/icc_buffer_mem.sv
`timescale 1ns/1ps
// Small capture buffer store with a registered read port.
module icc_buffer_mem
    import icc_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic [ICC_PTR_W-1:0] wr_addr_in,
    input wire logic [ICC_DATA_W-1:0] wr_data_in,
    input wire logic [ICC_PTR_W-1:0] rd_addr_in,
    output logic [ICC_DATA_W-1:0] rd_data_out
);

    logic [ICC_DATA_W-1:0] mem_q [ICC_DEPTH]; // Storage words.
    logic [ICC_DATA_W-1:0] mem_d [ICC_DEPTH];
    logic [ICC_DATA_W-1:0] rd_q; // Registered read word.
    logic [ICC_DATA_W-1:0] rd_d;

    // Write-through keeps the head word correct when it is written and read together.
    always_comb begin
        for (int i = 0; i < ICC_DEPTH; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wr_en_in) begin
            mem_d[wr_addr_in] = wr_data_in;
        end
        if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
            rd_d = wr_data_in;
        end else begin
            rd_d = mem_q[rd_addr_in];
        end
    end

    // Storage and read register.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < ICC_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            rd_q <= '0;
        end else begin
            mem_q <= mem_d;
            rd_q <= rd_d;
        end
    end

    assign rd_data_out = rd_q;

endmodule : icc_buffer_mem

// ### core/icc_top.sv
`timescale 1ns/1ps
// Input capture control: samples a timer count on qualified pin edges.
module icc_top
    import icc_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [ICC_ADDR_W-1:0] addr_in,
    input wire logic [ICC_DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [ICC_DATA_W-1:0] rdata_out,
    input wire logic capture_pin_in,
    input wire logic idle_in,
    input wire logic [15:0] second_timer_count_in,
    input wire logic [15:0] third_timer_count_in,
    input wire logic [ICC_DATA_W-1:0] wide_timer_count_in,
    output logic irq_out
);

    // Edge pulses from the synchronised pin.
    logic pin_rise;
    logic pin_fall;

    // Control register and its next value.
    icc_ctrl_t ctrl_q;
    icc_ctrl_t ctrl_d;

    // Buffer bookkeeping.
    logic [ICC_PTR_W-1:0] wr_ptr_q;
    logic [ICC_PTR_W-1:0] wr_ptr_d;
    logic [ICC_PTR_W-1:0] rd_ptr_q;
    logic [ICC_PTR_W-1:0] rd_ptr_d;
    logic [ICC_CNT_W-1:0] count_q;
    logic [ICC_CNT_W-1:0] count_d;
    logic ovf_q; // Overflow status flag.
    logic ovf_d;

    // Event qualification state.
    logic [3:0] prescale_q; // Counts rising edges in divided modes.
    logic [3:0] prescale_d;
    logic first_done_q; // Alternating mode has taken its first edge.
    logic first_done_d;
    logic [1:0] rate_cnt_q; // Captures since the last interrupt.
    logic [1:0] rate_cnt_d;

    // Interrupt registers.
    logic [ICC_IRQ_W-1:0] status_q;
    logic [ICC_IRQ_W-1:0] status_d;
    logic [ICC_IRQ_W-1:0] mask_q;
    logic [ICC_IRQ_W-1:0] mask_d;
    logic irq_q;
    logic irq_d;

    // Bus read data register.
    logic [ICC_DATA_W-1:0] rdata_q;
    logic [ICC_DATA_W-1:0] rdata_d;

    // Combinational helpers.
    icc_sel_t sel; // Decoded register.
    logic active; // Unit enabled and not halted by idle.
    logic event_hit; // Qualified capture event this cycle.
    logic push; // Word enters the buffer.
    logic pop; // Word leaves the buffer.
    logic full;
    logic [ICC_DATA_W-1:0] cap_value; // Selected timer count.
    logic [ICC_DATA_W-1:0] head_word; // Oldest word in the buffer.
    logic [ICC_IRQ_W-1:0] irq_set; // Interrupt events this cycle.

    // Pin synchroniser and edge detector.
    icc_edge_sync u_edge (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .pin_in(capture_pin_in),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    // Buffer store; the read address runs one step ahead so the head word is ready.
    icc_buffer_mem u_mem (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .wr_en_in(push),
        .wr_addr_in(wr_ptr_q),
        .wr_data_in(cap_value),
        .rd_addr_in(rd_ptr_d),
        .rd_data_out(head_word)
    );

    // Address decoding shared by the read and write paths.
    always_comb begin
        sel = icc_decode(addr_in);
    end

    // Counter source choice and event qualification.
    always_comb begin
        if (ctrl_q.wide_capture_select) begin
            cap_value = wide_timer_count_in;
        end else if (ctrl_q.timer_source_select) begin
            cap_value = {16'h0000, second_timer_count_in};
        end else begin
            cap_value = {16'h0000, third_timer_count_in};
        end
        // Halting in idle freezes the whole capture path, not just the buffer.
        active = ctrl_q.enable && !(ctrl_q.stop_in_idle && idle_in);
        prescale_d = prescale_q;
        first_done_d = first_done_q;
        event_hit = 1'b0;
        if (!ctrl_q.enable) begin
            // Disabled unit forgets any partial prescale or edge history.
            prescale_d = 4'h0;
            first_done_d = 1'b0;
        end else if (active) begin
            unique case (ctrl_q.capture_mode_field)
                ICC_MODE_OFF: begin
                    event_hit = 1'b0;
                end
                ICC_MODE_EVERY_EDGE, ICC_MODE_ANY_EDGE: begin
                    event_hit = pin_rise | pin_fall;
                end
                ICC_MODE_FALL: begin
                    event_hit = pin_fall;
                end
                ICC_MODE_RISE: begin
                    event_hit = pin_rise;
                end
                ICC_MODE_RISE_4, ICC_MODE_RISE_16: begin
                    // Capture on the last rising edge of each group.
                    if (pin_rise) begin
                        if (prescale_q == ((ctrl_q.capture_mode_field == ICC_MODE_RISE_4)
                                ? ICC_PRESCALE_4 : ICC_PRESCALE_16)) begin
                            event_hit = 1'b1;
                            prescale_d = 4'h0;
                        end else begin
                            prescale_d = prescale_q + 4'h1;
                        end
                    end
                end
                ICC_MODE_ALTERNATE: begin
                    // The first capture waits for the chosen edge, then every edge counts.
                    if (!first_done_q) begin
                        event_hit = ctrl_q.first_edge_select ? pin_rise : pin_fall;
                        first_done_d = event_hit;
                    end else begin
                        event_hit = pin_rise | pin_fall;
                    end
                end
            endcase
        end
    end

    // Buffer pointers, fill count and overflow flag.
    always_comb begin
        full = (count_q == ICC_CNT_W'(ICC_DEPTH));
        push = event_hit && !full;
        pop = rd_in && (sel == ICC_SEL_BUF) && (count_q != '0) && ctrl_q.enable;
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        ovf_d = ovf_q;
        if (!ctrl_q.enable) begin
            // Disabling empties the buffer and clears the overflow.
            wr_ptr_d = '0;
            rd_ptr_d = '0;
            count_d = '0;
            ovf_d = 1'b0;
        end else begin
            if (push) begin
                wr_ptr_d = wr_ptr_q + ICC_PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_d = rd_ptr_q + ICC_PTR_W'(1);
            end
            count_d = count_q + ICC_CNT_W'(push) - ICC_CNT_W'(pop);
            // A read clears the overflow, but a new overrun in the same cycle wins.
            if (pop) begin
                ovf_d = 1'b0;
            end
            if (event_hit && full) begin
                ovf_d = 1'b1;
            end
        end
    end

    // Interrupt rate divider and sticky status.
    always_comb begin
        rate_cnt_d = rate_cnt_q;
        irq_set = '0;
        if (!ctrl_q.enable) begin
            rate_cnt_d = 2'h0;
        end else begin
            if (push) begin
                if (rate_cnt_q == ctrl_q.interrupt_rate) begin
                    irq_set[ICC_IRQ_CAPTURE] = 1'b1;
                    rate_cnt_d = 2'h0;
                end else begin
                    rate_cnt_d = rate_cnt_q + 2'h1;
                end
            end
            irq_set[ICC_IRQ_OVERFLOW] = event_hit && full;
        end
        status_d = status_q;
        mask_d = mask_q;
        if (wr_in && (sel == ICC_SEL_STAT)) begin
            status_d = status_q & ~wdata_in[ICC_IRQ_W-1:0];
        end
        // Setting after clearing keeps an event that lands on the clear cycle.
        status_d = status_d | irq_set;
        if (wr_in && (sel == ICC_SEL_MASK)) begin
            mask_d = wdata_in[ICC_IRQ_W-1:0];
        end
        // A disabled unit never raises its line, even with stale status.
        irq_d = ctrl_q.enable && |(status_d & mask_d);
    end

    // Control register writes.
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_in && (sel == ICC_SEL_CTRL)) begin
            ctrl_d.enable = wdata_in[ICC_BIT_ENABLE];
            // Settings change only while the unit is off, so a capture never
            // sees a half-changed configuration.
            if (!ctrl_q.enable) begin
                ctrl_d.stop_in_idle = wdata_in[ICC_BIT_STOP_IN_IDLE];
                ctrl_d.first_edge_select = wdata_in[ICC_BIT_FIRST_EDGE_SELECT];
                ctrl_d.wide_capture_select = wdata_in[ICC_BIT_WIDE];
                ctrl_d.timer_source_select = wdata_in[ICC_BIT_TSEL];
                ctrl_d.interrupt_rate = wdata_in[ICC_BIT_RATE +: 2];
                ctrl_d.capture_mode_field = icc_mode_t'(wdata_in[ICC_BIT_MODE +: 3]);
            end
            // Status bits and unimplemented positions are not stored at all.
        end
    end

    // Read data path; answers appear one cycle after the read strobe.
    always_comb begin
        rdata_d = '0;
        if (rd_in) begin
            unique case (sel)
                ICC_SEL_CTRL: begin
                    // Unimplemented bits stay zero.
                    rdata_d[ICC_BIT_ENABLE] = ctrl_q.enable;
                    rdata_d[ICC_BIT_STOP_IN_IDLE] = ctrl_q.stop_in_idle;
                    rdata_d[ICC_BIT_FIRST_EDGE_SELECT] = ctrl_q.first_edge_select;
                    rdata_d[ICC_BIT_WIDE] = ctrl_q.wide_capture_select;
                    rdata_d[ICC_BIT_TSEL] = ctrl_q.timer_source_select;
                    rdata_d[ICC_BIT_RATE +: 2] = ctrl_q.interrupt_rate;
                    rdata_d[ICC_BIT_OVF] = ovf_q;
                    rdata_d[ICC_BIT_BNE] = (count_q != '0);
                    rdata_d[ICC_BIT_MODE +: 3] = ctrl_q.capture_mode_field;
                end
                ICC_SEL_BUF: begin
                    // An empty buffer reads as zero and is not disturbed.
                    rdata_d = pop ? head_word : '0;
                end
                ICC_SEL_STAT: begin
                    rdata_d[ICC_IRQ_W-1:0] = status_q;
                end
                ICC_SEL_MASK: begin
                    rdata_d[ICC_IRQ_W-1:0] = mask_q;
                end
                ICC_SEL_NONE: begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    // All state registers.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q <= ICC_CTRL_RST;
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            ovf_q <= 1'b0;
            prescale_q <= 4'h0;
            first_done_q <= 1'b0;
            rate_cnt_q <= 2'h0;
            status_q <= ICC_IRQ_RST;
            mask_q <= ICC_IRQ_RST;
            irq_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            ovf_q <= ovf_d;
            prescale_q <= prescale_d;
            first_done_q <= first_done_d;
            rate_cnt_q <= rate_cnt_d;
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;
    assign irq_out = irq_q;

endmodule : icc_top

// ### tb/icc_chk.sv
`timescale 1ns/1ps
// Port-level checker for the capture unit; shadows control and mask writes.
module icc_chk
    import icc_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [ICC_ADDR_W-1:0] addr_in,
    input wire logic [ICC_DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [ICC_DATA_W-1:0] rdata_out,
    input wire logic irq_out
);
    logic [31:0] ctl_q; // Shadow of the writable control fields.
    logic [31:0] ctl_d; // Next shadow value.
    logic [ICC_IRQ_W-1:0] mask_q; // Shadow of the mask register.
    logic [ICC_IRQ_W-1:0] mask_d; // Next mask shadow.

    // Fields other than enable only load while the unit is off.
    always_comb begin
        ctl_d = ctl_q;
        mask_d = mask_q;
        if (wr_in && addr_in == ICC_OFS_CTRL) begin
            if (ctl_q[15]) begin
                ctl_d[15] = wdata_in[15];
            end else begin
                ctl_d = wdata_in & 32'h0000_a3e7;
            end
        end
        if (wr_in && addr_in == ICC_OFS_MASK) begin
            mask_d = wdata_in[ICC_IRQ_W-1:0];
        end
    end

    // Registers the shadows; reset matches the design's cleared control.
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ctl_q <= 32'h0;
            mask_q <= '0;
        end else begin
            ctl_q <= ctl_d;
            mask_q <= mask_d;
        end
    end

    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // Readback masks the status bits 4 and 3, which the shadow cannot know.
    a_ctrl_readback: assert property (
        $past(rd_in) && $past(addr_in) == ICC_OFS_CTRL
        |-> (rdata_out & 32'hffff_ffe7) == $past(ctl_q)) else $error("control readback off");
    a_unmapped_zero: assert property (
        $past(rd_in) && $past(addr_in[1:0]) != 2'h0 |-> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_quiet: assert property (
        !$past(rd_in) |-> rdata_out == 32'h0) else $error("read data outside its slot");
    // Two quiet cycles allow for the registered interrupt path.
    a_irq_disabled: assert property (
        !ctl_q[15] && !$past(ctl_q[15]) |-> !irq_out) else $error("interrupt while disabled");
    a_irq_masked: assert property (
        mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq_out)
        else $error("interrupt with all sources masked");
    a_flags_off: assert property (
        $past(rd_in) && $past(addr_in) == ICC_OFS_CTRL && !$past(ctl_q[15])
        && !$past(ctl_q[15], 2) |-> rdata_out[4:3] == 2'h0) else $error("flags set while off");
    a_buf_empty_read: assert property (
        $past(rd_in) && $past(addr_in) == ICC_OFS_BUF && !$past(ctl_q[15])
        && !$past(ctl_q[15], 2) |-> rdata_out == 32'h0) else $error("empty buffer gave data");
    a_narrow_upper: assert property (
        $past(rd_in) && $past(addr_in) == ICC_OFS_BUF && !$past(ctl_q[8])
        |-> rdata_out[31:16] == 16'h0) else $error("narrow capture has upper bits");
endmodule : icc_chk

bind icc_top icc_chk i_icc_chk (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .irq_out(irq_out)
);

// ### tb/icc_far_side.sv
`timescale 1ns/1ps
// Capture pin and timer counts seen by the unit. The timers are frozen
// between loads so that the captured word does not hinge on which of the
// two synchroniser cycles the edge lands in; the price is no running count.
module icc_far_side (
    output logic capture_pin_out,
    output logic [15:0] second_count_out,
    output logic [15:0] third_count_out,
    output logic [31:0] wide_count_out
);
    // Everything starts low so the first move of the pin is a clean rise.
    initial begin
        capture_pin_out = 1'b0;
        second_count_out = 16'h0;
        third_count_out = 16'h0;
        wide_count_out = 32'h0;
    end

    // Moves the pin; called right after a clock edge.
    task automatic set_pin(input logic level);
        capture_pin_out <= level;
    endtask : set_pin

    // Loads new timer values for the next capture.
    task automatic load_counts(input logic [15:0] s, input logic [15:0] t,
                               input logic [31:0] w);
        second_count_out <= s;
        third_count_out <= t;
        wide_count_out <= w;
    endtask : load_counts
endmodule : icc_far_side

// ### tb/icc_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the capture unit.
module icc_bench
    import icc_pkg::*;
;
    logic clock_in = 1'b0; // Bus clock, 50 ns period.
    logic rst_in = 1'b1; // Held high for the first three cycles.
    logic [3:0] addr = 4'h0; // Register address.
    logic [31:0] wdata = 32'h0; // Write data.
    logic wr_s = 1'b0; // Write strobe.
    logic rd_s = 1'b0; // Read strobe.
    logic idle = 1'b0; // Processor idle level.
    logic [31:0] rdata; // Read data from the unit.
    logic irq; // Interrupt level from the unit.
    logic pin; // Capture pin from the far side.
    logic [15:0] sec; // Second timer count.
    logic [15:0] thr; // Third timer count.
    logic [31:0] wide; // Wide timer count.
    int fails = 0; // Mismatches seen.
    int n_tests = 0; // Comparisons made.
    int cycles = 0; // Clock cycles since start.
    logic [31:0] mcw[5] = '{32'h8002, 32'h8004, 32'h8005, 32'h8006, 32'h8206}; // Mode words.
    int tgl[5] = '{2, 7, 31, 2, 2}; // Pin toggles up to the first capture.

    icc_top i_icc_top (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
        .capture_pin_in(pin), .idle_in(idle), .second_timer_count_in(sec),
        .third_timer_count_in(thr), .wide_timer_count_in(wide), .irq_out(irq));
    icc_far_side i_icc_far_side (.capture_pin_out(pin), .second_count_out(sec),
        .third_count_out(thr), .wide_count_out(wide));

    // Free-running clock.
    initial begin
        forever #25 clock_in = ~clock_in;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // A hang costs at most this many cycles; the tests need about 700.
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    // Compares one value and counts it.
    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_tests++;
        if (seen !== expd) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    // One-cycle write strobe.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock_in);
        wr_s <= 1'b0;
    endtask : wr

    // One-cycle read strobe; data are taken in the following cycle only.
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_in);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock_in);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // Disables, clears status, sets the mask, then writes the new control.
    task automatic arm(input logic [31:0] c, input logic [1:0] m);
        wr(ICC_OFS_CTRL, 32'h0);
        wr(ICC_OFS_STAT, 32'h3);
        wr(ICC_OFS_MASK, {30'h0, m});
        wr(ICC_OFS_CTRL, c);
    endtask : arm

    // Sets the pin and waits out synchroniser, push and interrupt latency.
    task automatic edge_at(input logic v);
        i_icc_far_side.set_pin(v);
        repeat (6) @(posedge clock_in);
    endtask : edge_at

    // Reads the buffer-not-empty flag.
    task automatic bne(output logic [31:0] f);
        logic [31:0] d;
        rd(ICC_OFS_CTRL, d);
        f = {31'h0, d[3]};
    endtask : bne

    // Expected captured word for a given width and timer choice.
    function automatic logic [31:0] exp_cap(input logic w32, input logic ts,
        input logic [15:0] s, input logic [15:0] t, input logic [31:0] w);
        if (w32) begin
            return w;
        end
        return ts ? {16'h0, s} : {16'h0, t};
    endfunction : exp_cap

    // Main sequence.
    initial begin
        logic [31:0] d;
        logic [31:0] c;
        logic [15:0] s;
        logic [15:0] t;
        logic [31:0] w;
        d = $urandom(12914);
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(ICC_OFS_CTRL, d);
        check(d, 32'h0);
        wr(4'h6, $urandom());
        rd(4'h6, d);
        check(d, 32'h0);
        $display("test reset_and_unmapped done");
        // Status bits written as ones must not stick; enabled writes keep fields.
        for (int i = 0; i < 4; i++) begin
            c = ($urandom() & 32'hffff_7fff) | 32'h0000_0018;
            wr(ICC_OFS_CTRL, c);
            rd(ICC_OFS_CTRL, d);
            check(d, c & 32'h0000_23e7);
            wr(ICC_OFS_CTRL, c | 32'h0000_8000);
            wr(ICC_OFS_CTRL, ~c);
            rd(ICC_OFS_CTRL, d);
            check(d & 32'hffff_ffe7, (c & 32'h0000_23e7) | 32'h0000_8000);
            wr(ICC_OFS_CTRL, 32'h0);
        end
        $display("test control_fields done");
        // Wide any-edge with timer select set, then second, then third timer.
        for (int i = 0; i < 3; i++) begin
            c = 32'h0000_8003 | (i == 0 ? 32'h184 : 32'h0) | (i == 1 ? 32'h80 : 32'h0);
            edge_at(1'b0);
            arm(c, 2'h0);
            s = 16'($urandom());
            t = 16'($urandom());
            w = $urandom();
            i_icc_far_side.load_counts(s, t, w);
            edge_at(1'b1);
            bne(d);
            check(d, 32'h1);
            rd(ICC_OFS_BUF, d);
            check(d, exp_cap(c[8], c[7], s, t, w));
            bne(d);
            check(d, 32'h0);
        end
        $display("test capture_source done");
        for (int r = 0; r < 4; r++) begin
            arm(32'h0000_8001 | (r << 5), 2'h1);
            for (int n = 1; n <= r + 1; n++) begin
                edge_at(!pin);
                check({31'h0, irq}, (n == r + 1) ? 32'h1 : 32'h0);
            end
            wr(ICC_OFS_STAT, 32'h1);
            repeat (2) @(posedge clock_in);
            check({31'h0, irq}, 32'h0);
        end
        $display("test interrupt_rate done");
        arm(32'h0000_8001, 2'h2);
        for (int n = 0; n < 5; n++) begin
            edge_at(!pin);
        end
        rd(ICC_OFS_CTRL, d);
        check({30'h0, d[4:3]}, 32'h3);
        check({31'h0, irq}, 32'h1);
        rd(ICC_OFS_BUF, d);
        check(d, {16'h0, t});
        rd(ICC_OFS_CTRL, d);
        check({30'h0, d[4:3]}, 32'h1);
        wr(ICC_OFS_CTRL, 32'h0);
        repeat (2) @(posedge clock_in);
        check({31'h0, irq}, 32'h0);
        rd(ICC_OFS_BUF, d);
        check(d, 32'h0);
        $display("test overflow_and_disable done");
        for (int m = 0; m < 5; m++) begin
            edge_at(mcw[m][9]);
            arm(mcw[m], 2'h0);
            repeat (tgl[m] - 1) edge_at(!pin);
            bne(d);
            check(d, 32'h0);
            edge_at(!pin);
            bne(d);
            check(d, 32'h1);
        end
        $display("test first_edge done");
        arm(32'h0000_a001, 2'h0);
        idle <= 1'b1;
        edge_at(!pin);
        bne(d);
        check(d, 32'h0);
        idle <= 1'b0;
        edge_at(!pin);
        bne(d);
        check(d, 32'h1);
        arm(32'h0000_8001, 2'h0);
        idle <= 1'b1;
        edge_at(!pin);
        bne(d);
        check(d, 32'h1);
        idle <= 1'b0;
        $display("test stop_in_idle done");
        tally_and_finish();
    end
endmodule : icc_bench
